//--- rtl/pft_pkg.sv
package pft_pkg;
   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int PFT_ADDR_W = 15;
   localparam int PFT_WORD_W = 16;
   localparam int PFT_MEM_WORDS = 32768;
   localparam int PFT_STACK_DEPTH = 8;
   localparam int PFT_SP_W = 4;
   localparam int PFT_BANK_W = 2;
   localparam int PFT_HIGH_W = 5;
   localparam logic [14:0] PFT_RESET_VECTOR = 15'h0000;
   localparam logic [6:0] PFT_LAST_PAGE = 7'h7f;

   // ----------------------------------------------------------------
   // Register port offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] PFT_REG_PC_LOW = 4'h0;
   localparam logic [3:0] PFT_REG_TBL_LOW = 4'h1;
   localparam logic [3:0] PFT_REG_TBL_HIGH = 4'h2;
   localparam logic [3:0] PFT_REG_TDATA_HIGH = 4'h3;
   localparam logic [3:0] PFT_REG_BANK = 4'h4;
   localparam logic [3:0] PFT_REG_STATUS = 4'h5;
   localparam logic [7:0] PFT_RESET_BYTE = 8'h00;

   // ----------------------------------------------------------------
   // Status bit positions
   // ----------------------------------------------------------------
   localparam int PFT_ST_C = 0;
   localparam int PFT_ST_AC = 1;
   localparam int PFT_ST_Z = 2;
   localparam int PFT_ST_OV = 3;

   // ----------------------------------------------------------------
   // Flow commands from the decoder
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      PFT_OP_NEXT = 4'h0,
      PFT_OP_JUMP = 4'h1,
      PFT_OP_CALL = 4'h2,
      PFT_OP_RET = 4'h3,
      PFT_OP_RETURN_FROM_IRQ_OP = 4'h4,
      PFT_OP_SKIP = 4'h5,
      PFT_OP_TABRD = 4'h6,
      PFT_OP_TABRD_LAST = 4'h7,
      PFT_OP_EXT_TABRD = 4'h8,
      PFT_OP_EXT_TABRD_LAST = 4'h9
   } pft_op_t;

   typedef enum logic [2:0] {
      PFT_ST_RUN = 3'b001,
      PFT_ST_DUMMY = 3'b010,
      PFT_ST_TABLE = 3'b100
   } pft_state_t;

   typedef struct packed {
      pft_op_t op;
      logic skip_taken;
      logic [14:0] target;
      logic [7:0] dest_addr;
      logic dest_sector0;
   } pft_cmd_t;

   typedef struct packed {
      logic valid;
      logic c;
      logic ac;
      logic z;
      logic ov;
   } pft_alu_flags_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic [7:0] addr;
      logic ext;
   } pft_table_wr_t;
endpackage

//--- rtl/pft_stack.sv
module pft_stack
   import pft_pkg::*;
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [14:0] push_data_i,
   output logic [14:0] top_o,
   output logic full_o,
   output logic empty_o
);
   // Circular store, so an overflowing push overwrites the oldest entry
   logic [14:0] mem [PFT_STACK_DEPTH];
   logic [PFT_SP_W-1:0] count;
   logic [PFT_SP_W-2:0] wr_ptr;
   wire [PFT_SP_W-2:0] rd_ptr = wr_ptr - 3'h1;

   assign top_o = mem[rd_ptr];
   assign full_o = (count == 4'(PFT_STACK_DEPTH));
   assign empty_o = (count == 4'h0);

   always_ff @(posedge mclk_i) begin
      if (push_i) begin
         mem[wr_ptr] <= push_data_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         count <= 4'h0;
         wr_ptr <= 3'h0;
      end else if (push_i) begin
         wr_ptr <= wr_ptr + 3'h1;
         if (!full_o) begin
            count <= count + 4'h1;
         end
      end else if (pop_i && !empty_o) begin
         wr_ptr <= rd_ptr;
         count <= count - 4'h1;
      end
   end
endmodule

//--- rtl/pft_flow.sv
// The register addresses and the strobed register port were decided locally.
module pft_flow
   import pft_pkg::*;
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Decoder
   input wire pft_cmd_t cmd_i,
   input wire logic cmd_valid_i,
   input wire pft_alu_flags_t alu_flags_i,
   // Interrupt logic
   input wire logic irq_req_i,
   input wire logic [14:0] irq_vector_i,
   output logic irq_ack_o,
   // Program memory
   output logic [14:0] pmem_addr_o,
   input wire logic [15:0] pmem_data_i,
   // Execution state
   output logic [14:0] pc_o,
   output logic dummy_o,
   output logic stall_o,
   output logic stack_full_o,
   output pft_table_wr_t table_wr_o,
   output logic [7:0] status_o
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   pft_state_t state;
   pft_state_t next_state;
   logic [14:0] pc;
   logic [14:0] next_pc;
   logic [7:0] tbl_low;
   logic [6:0] tbl_high;
   logic [7:0] tdata_high;
   logic [7:0] status;
   logic [7:0] tbl_dest;
   logic tbl_ext;
   logic [14:0] tbl_addr_q;
   logic [7:0] rdata;
   pft_table_wr_t table_wr;

   logic stack_full;
   logic stack_empty;
   logic [14:0] stack_top;

   function automatic logic [14:0] pft_page_jump(input logic [14:0] base,
                                                 input logic [7:0] low);
      pft_page_jump = {base[14:8], low};
   endfunction

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire running = (state == PFT_ST_RUN);
   wire exec = running && cmd_valid_i;
   wire op_call = exec && (cmd_i.op == PFT_OP_CALL);
   wire op_ret = exec && ((cmd_i.op == PFT_OP_RET) || (cmd_i.op == PFT_OP_RETURN_FROM_IRQ_OP));
   wire op_jump = exec && (cmd_i.op == PFT_OP_JUMP);
   wire op_skip = exec && (cmd_i.op == PFT_OP_SKIP) && cmd_i.skip_taken;
   wire op_last = (cmd_i.op == PFT_OP_TABRD_LAST) || (cmd_i.op == PFT_OP_EXT_TABRD_LAST);
   wire op_ext = (cmd_i.op == PFT_OP_EXT_TABRD) || (cmd_i.op == PFT_OP_EXT_TABRD_LAST);
   wire op_tab_any = (cmd_i.op == PFT_OP_TABRD) || (cmd_i.op == PFT_OP_TABRD_LAST) || op_ext;
   // Sector 0 destinations use the short forms, others the extended ones
   wire op_table = exec && op_tab_any && (op_ext != cmd_i.dest_sector0);
   wire pcl_wr = running && reg_wr_i && (reg_addr_i == PFT_REG_PC_LOW);

   // Interrupt is only taken on an idle instruction boundary
   wire irq_take = running && irq_req_i && !stack_full && !cmd_valid_i && !pcl_wr;

   wire [14:0] tbl_addr = op_last ? {PFT_LAST_PAGE, tbl_low}
                                  : pft_page_jump({tbl_high, 8'h00}, tbl_low);

   // ----------------------------------------------------------------
   // Next program counter
   // ----------------------------------------------------------------
   always_comb begin
      next_pc = pc;
      next_state = state;
      unique case (state)
         PFT_ST_RUN: begin
            if (irq_take) begin
               next_pc = irq_vector_i;
               next_state = PFT_ST_DUMMY;
            end else if (pcl_wr) begin
               next_pc = pft_page_jump(pc, reg_wdata_i);
               next_state = PFT_ST_DUMMY;
            end else if (op_jump || op_call) begin
               next_pc = cmd_i.target;
               next_state = PFT_ST_DUMMY;
            end else if (op_ret) begin
               next_pc = stack_top;
               next_state = PFT_ST_DUMMY;
            end else if (op_skip) begin
               next_pc = pc + 15'h1;
               next_state = PFT_ST_DUMMY;
            end else if (op_table) begin
               next_state = PFT_ST_TABLE;
            end else if (exec) begin
               next_pc = pc + 15'h1;
            end
         end
         PFT_ST_DUMMY: begin
            next_state = PFT_ST_RUN;
         end
         PFT_ST_TABLE: begin
            next_pc = pc + 15'h1;
            next_state = PFT_ST_RUN;
         end
         default: begin
            next_state = PFT_ST_RUN;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Return stack, not visible on the register port
   // ----------------------------------------------------------------
   pft_stack u_stack (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .push_i(op_call || irq_take),
      .pop_i(op_ret),
      // An interrupt saves the unexecuted instruction, a call the one after it
      .push_data_i(irq_take ? pc : pc + 15'h1),
      .top_o(stack_top),
      .full_o(stack_full),
      .empty_o(stack_empty)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         state <= PFT_ST_RUN;
         pc <= PFT_RESET_VECTOR;
      end else begin
         state <= next_state;
         pc <= next_pc;
      end
   end

   // Table read: address latched first cycle, data taken second
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         tbl_addr_q <= PFT_RESET_VECTOR;
         tbl_dest <= PFT_RESET_BYTE;
         tbl_ext <= 1'b0;
      end else if (op_table) begin
         tbl_addr_q <= tbl_addr;
         tbl_dest <= cmd_i.dest_addr;
         tbl_ext <= op_ext;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         table_wr <= '0;
      end else begin
         table_wr.valid <= (state == PFT_ST_TABLE);
         table_wr.data <= pmem_data_i[7:0];
         table_wr.addr <= tbl_dest;
         table_wr.ext <= tbl_ext;
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         tbl_low <= PFT_RESET_BYTE;
         tbl_high <= 7'h00;
         tdata_high <= PFT_RESET_BYTE;
      end else begin
         if (reg_wr_i && reg_addr_i == PFT_REG_TBL_LOW) begin
            tbl_low <= reg_wdata_i;
         end
         if (reg_wr_i && reg_addr_i == PFT_REG_TBL_HIGH) begin
            tbl_high <= reg_wdata_i[6:0];
         end
         // Hardware load wins over a software write in the same cycle
         if (state == PFT_ST_TABLE) begin
            tdata_high <= pmem_data_i[15:8];
         end else if (reg_wr_i && reg_addr_i == PFT_REG_TDATA_HIGH) begin
            tdata_high <= reg_wdata_i;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         status <= PFT_RESET_BYTE;
      end else if (alu_flags_i.valid) begin
         status[PFT_ST_C] <= alu_flags_i.c;
         status[PFT_ST_AC] <= alu_flags_i.ac;
         status[PFT_ST_Z] <= alu_flags_i.z;
         status[PFT_ST_OV] <= alu_flags_i.ov;
      end else if (reg_wr_i && reg_addr_i == PFT_REG_STATUS) begin
         status <= {4'h0, reg_wdata_i[3:0]};
      end
   end

   // Bank bits mirror the upper PC bits; writes go through jumps, calls, returns and interrupts only
   wire [7:0] bank_view = {6'h00, pc[14:13]};
   wire [7:0] rd_mux = (reg_addr_i == PFT_REG_PC_LOW) ? pc[7:0] :
                       (reg_addr_i == PFT_REG_TBL_LOW) ? tbl_low :
                       (reg_addr_i == PFT_REG_TBL_HIGH) ? {1'b0, tbl_high} :
                       (reg_addr_i == PFT_REG_TDATA_HIGH) ? tdata_high :
                       (reg_addr_i == PFT_REG_BANK) ? bank_view :
                       (reg_addr_i == PFT_REG_STATUS) ? status : 8'h00;

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         rdata <= PFT_RESET_BYTE;
      end else if (reg_rd_i) begin
         rdata <= rd_mux;
      end else begin
         rdata <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // 15-bit address spans 32K words of 16 bits
   assign pmem_addr_o = (state == PFT_ST_TABLE) ? tbl_addr_q : pc;
   assign pc_o = pc;
   assign dummy_o = (state == PFT_ST_DUMMY);
   assign stall_o = (state != PFT_ST_RUN);
   assign irq_ack_o = irq_take;
   assign stack_full_o = stack_full;
   assign table_wr_o = table_wr;
   assign status_o = status;
   assign reg_rdata_o = rdata;
endmodule

//--- verification/pft_monitor.sv
module pft_monitor
   import pft_pkg::*;
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire pft_cmd_t cmd_i,
   input wire logic cmd_valid_i,
   input wire pft_alu_flags_t alu_flags_i,
   input wire logic irq_req_i,
   input wire logic [14:0] irq_vector_i,
   input wire logic irq_ack_o,
   input wire logic [14:0] pmem_addr_o,
   input wire logic [15:0] pmem_data_i,
   input wire logic [14:0] pc_o,
   input wire logic dummy_o,
   input wire logic stall_o,
   input wire logic stack_full_o,
   input wire pft_table_wr_t table_wr_o,
   input wire logic [7:0] status_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   wire run_cmd = cmd_valid_i && !stall_o;
   wire pcl_wr = reg_wr_i && reg_addr_i == PFT_REG_PC_LOW && !stall_o && !cmd_valid_i;
   // ----------------------------------------------------------------
   // Table read steps
   // ----------------------------------------------------------------
   sequence tab_go;
      run_cmd && cmd_i.op == PFT_OP_TABRD && cmd_i.dest_sector0;
   endsequence
   sequence tab_done;
      stall_o && !table_wr_o.valid ##1
         table_wr_o.valid && table_wr_o.data == $past(pmem_data_i[7:0]);
   endsequence
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   reset_vector_a:
      assert property ($rose(resetn_i) |-> pc_o == PFT_RESET_VECTOR && !stack_full_o)
      else $error("pc or stack not cleared by reset");
   seq_step_a:
      assert property (run_cmd && cmd_i.op == PFT_OP_NEXT |=> pc_o == $past(pc_o) + 15'h0001)
      else $error("sequential step did not add one");
   jump_load_a:
      assert property (run_cmd && cmd_i.op == PFT_OP_JUMP |=> dummy_o && pc_o == $past(cmd_i.target))
      else $error("jump target not loaded");
   skip_dummy_a:
      assert property (run_cmd && cmd_i.op == PFT_OP_SKIP && cmd_i.skip_taken |=> dummy_o ##1 !dummy_o)
      else $error("taken skip without single dummy");
   pcl_page_a:
      assert property (pcl_wr |=> dummy_o && pc_o == {$past(pc_o[14:8]), $past(reg_wdata_i)})
      else $error("low byte write left page or no dummy");
   irq_gate_a:
      assert property (irq_ack_o |-> irq_req_i && !stack_full_o && !stall_o && !cmd_valid_i)
      else $error("interrupt acknowledged when not allowed");
   irq_vector_a:
      assert property (irq_ack_o |=> dummy_o && pc_o == $past(irq_vector_i))
      else $error("interrupt vector not loaded");
   tab_two_a:
      assert property (tab_go |=> tab_done)
      else $error("table read not two cycles");
   last_page_a:
      assert property (run_cmd && cmd_i.op == PFT_OP_TABRD_LAST && cmd_i.dest_sector0
         |=> pmem_addr_o[14:8] == PFT_LAST_PAGE) else $error("last page not addressed");
   status_upd_a:
      assert property (alu_flags_i.valid |=> status_o[3:0] == $past({alu_flags_i.ov,
         alu_flags_i.z, alu_flags_i.ac, alu_flags_i.c})) else $error("status not updated");
endmodule

//--- verification/pft_pmem_model.sv
module pft_pmem_model #(
   parameter logic [14:0] VEC = 15'h0008
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic [14:0] addr_i,
   output logic [15:0] data_o,
   input wire logic raise_i,
   input wire logic enable_i,
   input wire logic ack_i,
   output logic req_o,
   output logic [14:0] vector_o
);
   logic flag;
   // The high byte follows address bits 7 to 0, the low byte bits 14 to 7, so a wrong word shows
   assign data_o = {addr_i[7:0] ^ 8'h5a, addr_i[14:7]};
   assign vector_o = VEC;
   assign req_o = flag && enable_i;
   // Request stays recorded until acknowledged
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) flag <= 1'b0;
      else if (raise_i) flag <= 1'b1;
      else if (ack_i) flag <= 1'b0;
   end
endmodule

//--- verification/tb_top.sv
module tb_top
   import pft_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {pft_op_t op; logic sk; logic [14:0] tg; logic [14:0] pc; logic d;} pft_row_t;
   logic mclk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0, cmd_valid_i = 0, irq_raise = 0;
   logic [3:0] reg_addr_i = '0;
   logic [7:0] reg_wdata_i = '0, reg_rdata_o, status_o, rd_val;
   pft_cmd_t cmd_i = '0;
   pft_alu_flags_t alu_flags_i = '0;
   logic irq_req_i, irq_ack_o, dummy_o, stall_o, stack_full_o;
   logic [14:0] irq_vector_i, pmem_addr_o, pc_o, ea;
   logic [15:0] pmem_data_i;
   pft_table_wr_t table_wr_o;
   int num_errors = 0, check_count = 0;
   pft_op_t tops [4] = '{PFT_OP_TABRD, PFT_OP_TABRD_LAST, PFT_OP_EXT_TABRD, PFT_OP_EXT_TABRD_LAST};
   pft_row_t rows [9] = '{'{PFT_OP_NEXT, 0, 0, 15'h0001, 0}, '{PFT_OP_JUMP, 0, 15'h1234, 15'h1234, 1},
      '{PFT_OP_CALL, 0, 15'h2200, 15'h2200, 1}, '{PFT_OP_SKIP, 1, 0, 15'h2201, 1},
      '{PFT_OP_NEXT, 0, 0, 15'h2202, 0}, '{PFT_OP_RET, 0, 0, 15'h1235, 1},
      '{PFT_OP_CALL, 0, 15'h3000, 15'h3000, 1}, '{PFT_OP_RETURN_FROM_IRQ_OP, 0, 0, 15'h1236, 1},
      '{PFT_OP_SKIP, 0, 0, 15'h1237, 0}};
   always #5 mclk_i = ~mclk_i;
   pft_flow dut (.mclk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .cmd_i, .cmd_valid_i, .alu_flags_i, .irq_req_i, .irq_vector_i, .irq_ack_o, .pmem_addr_o,
      .pmem_data_i, .pc_o, .dummy_o, .stall_o, .stack_full_o, .table_wr_o, .status_o);
   pft_pmem_model #(.VEC(15'h0008)) far (.mclk_i, .resetn_i, .addr_i(pmem_addr_o),
      .data_o(pmem_data_i), .raise_i(irq_raise), .enable_i(1'b1), .ack_i(irq_ack_o),
      .req_o(irq_req_i), .vector_o(irq_vector_i));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic step(input pft_op_t op, input logic sk, input logic [14:0] tg, input logic s0);
      @(posedge mclk_i);
      cmd_i <= '{op, sk, tg, 8'h40, s0};
      cmd_valid_i <= 1'b1;
      @(posedge mclk_i);
      cmd_valid_i <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 rd_val = reg_rdata_o;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge mclk_i);
      resetn_i <= 1'b1;
      #1 chk(pc_o, 0);
      foreach (rows[i]) begin
         step(rows[i].op, rows[i].sk, rows[i].tg, 1'b1);
         chk(pc_o, rows[i].pc);
         chk(dummy_o, rows[i].d);
      end
      wr(PFT_REG_PC_LOW, 8'h80);
      chk(pc_o, 15'h1280);
      chk(dummy_o, 1);
      rd(PFT_REG_PC_LOW);
      chk(rd_val, 8'h80);
      rd(4'hf);
      chk(rd_val, 8'h00);
      wr(PFT_REG_TDATA_HIGH, 8'ha5);
      rd(PFT_REG_TDATA_HIGH);
      chk(rd_val, 8'ha5);
      @(posedge mclk_i) alu_flags_i <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
      @(posedge mclk_i) alu_flags_i <= '0;
      rd(PFT_REG_STATUS);
      chk(rd_val, 8'h0d);
      wr(PFT_REG_TBL_LOW, 8'h06);
      wr(PFT_REG_TBL_HIGH, 8'h12);
      for (int k = 0; k < 4; k++) begin
         ea = {(k % 2 == 1) ? PFT_LAST_PAGE : 7'h12, 8'h06};
         step(tops[k], 1'b0, 15'h0000, k < 2);
         chk(pmem_addr_o, ea);
         @(posedge mclk_i);
         #1 chk(table_wr_o, {1'b1, ea[14:7], 8'h40, k >= 2});
         rd(PFT_REG_TDATA_HIGH);
         chk(rd_val, ea[7:0] ^ 8'h5a);
      end
      ea = pc_o;
      step(PFT_OP_EXT_TABRD, 1'b0, 15'h0000, 1'b1);
      chk({stall_o, pc_o}, {1'b0, ea + 15'h0001});
      for (int k = 0; k < 9; k++) step(PFT_OP_CALL, 1'b0, 15'h4000 + 15'(k * 16), 1'b1);
      chk({stack_full_o, pc_o}, {1'b1, 15'h4080});
      @(posedge mclk_i) irq_raise <= 1'b1;
      @(posedge mclk_i) irq_raise <= 1'b0;
      repeat (4) @(posedge mclk_i);
      #1 chk(pc_o, 15'h4080);
      step(PFT_OP_RET, 1'b0, 15'h0000, 1'b1);
      chk(pc_o, 15'h4071);
      repeat (2) @(posedge mclk_i);
      #1 chk(pc_o, 15'h0008);
      step(PFT_OP_RETURN_FROM_IRQ_OP, 1'b0, 15'h0000, 1'b1);
      chk(pc_o, 15'h4071);
      repeat (7) step(PFT_OP_RET, 1'b0, 15'h0000, 1'b1);
      chk(pc_o, 15'h4001);
      step(PFT_OP_CALL, 1'b0, 15'h5000, 1'b1);
      repeat (7) step(PFT_OP_CALL, 1'b0, 15'h5100, 1'b1);
      chk(stack_full_o, 1);
      @(posedge mclk_i) resetn_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      resetn_i <= 1'b1;
      #1 chk({stack_full_o, pc_o}, 0);
      tally_and_finish();
   end
   initial begin
      repeat (3000) @(posedge mclk_i);
      num_errors++;
      tally_and_finish();
   end
endmodule

bind pft_flow pft_monitor mon (.mclk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .cmd_i,
   .cmd_valid_i, .alu_flags_i, .irq_req_i, .irq_vector_i, .irq_ack_o, .pmem_addr_o, .pmem_data_i,
   .pc_o, .dummy_o, .stall_o, .stack_full_o, .table_wr_o, .status_o);
